// ### rtl/tpg_pkg.sv
package tpg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, word aligned byte addresses.
  localparam logic [7:0] ADDR_SCALE_SELECT = 8'h00;
  localparam logic [7:0] ADDR_CAPABILITY = 8'h04;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Field positions shared by the capability and mode control registers.
  localparam int CONTINUOUS_MODE_POS = 17;
  localparam int TIMED_MODE_POS = 16;
  localparam int ONES_ZEROS_POS = 3;
  localparam int ALTERNATING_BYTE_POS = 2;
  localparam int WALKING_ZERO_POS = 1;
  localparam int WALKING_ONE_POS = 0;

  // Trigger scale select stages, as exponents of two.
  localparam int SCALE_STAGES = 5;
  localparam logic [4:0] SCALE_EXP_65536 = 5'h10;
  localparam logic [4:0] SCALE_EXP_256 = 5'h08;
  localparam logic [4:0] SCALE_EXP_16 = 5'h04;
  localparam logic [4:0] SCALE_EXP_4 = 5'h02;
  localparam logic [4:0] SCALE_EXP_2 = 5'h01;

  // Reset values.
  localparam logic [4:0] SCALE_RESET = 5'h00;
  localparam logic [17:0] MODE_RESET = 18'h00000;

  // Capability word: both modes and all four patterns are supported.
  localparam logic [31:0] CAPABILITY_VALUE = 32'h0003000F;

  // Trace port width and pattern byte values.
  localparam int TRACE_WIDTH = 32;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ALL_ZEROS = 8'h00;
  localparam logic [7:0] BYTE_ALT_A = 8'hAA;
  localparam logic [7:0] BYTE_ALT_B = 8'h55;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } tpg_bus_req_type;

  // Complete state of the block.
  typedef struct packed {
    logic [4:0] scale;
    logic cont;
    logic timed;
    logic [3:0] pat_en;
    logic armed;
    logic [7:0] trig_cnt;
    logic [30:0] prescale;
    logic trig_pulse;
    logic [1:0] pat_sel;
    logic [7:0] rep_cnt;
    logic [4:0] step;
    logic active;
    logic [31:0] trace;
    logic [31:0] rdata;
  } tpg_state_type;

endpackage : tpg_pkg

// ### rtl/tpg_top.sv
// Summary of operation
// R01 - Scale select bit four multiplies the trigger count by 65536.
// R02 - Scale select bit three multiplies the trigger count by 256.
// R03 - Scale select bit two multiplies the trigger count by 16.
// R04 - Scale select bit one multiplies the trigger count by 4.
// R05 - Scale select bit zero multiplies the trigger count by 2.
// R06 - Enabled stages combine multiplicatively; all clear means a multiplier of one.
// R07 - Writing the scale select reloads the trigger counter and clears the prescaler.
// R08 - A read-only capability register lists the patterns the port can drive.
// R09 - Capability bit seventeen reads one: continuous mode supported.
// R10 - Capability bit sixteen reads one: timed mode supported.
// R11 - Capability bits three to zero read one: all four patterns supported.
// R12 - Continuous and timed mode are never both selected.
// R13 - Any combination of the four pattern enables may be set together.
// R14 - Timed mode clears itself after its cycles and returns to off.
// R15 - The mode control register resets to zero: off, no pattern.
// R16 - Mode control bit seventeen enables continuous mode.
// R17 - Mode control bit sixteen enables timed mode.
// R18 - Mode control bit three enables the all-ones/all-zeros pattern.
// R19 - Mode control bit two enables the AA/55 pattern.
// R20 - Mode control bit one enables the walking zeros pattern.
// R21 - Mode control bit zero enables the walking ones pattern.
// R22 - Each pattern runs for the repeat count of cycles (one cycle for a count of zero), then moves on.
// R23 - Walking patterns shift one bit per cycle; byte patterns alternate per cycle.
// R24 - Patterns run lowest enabled bit first, repeating while continuous mode holds.
//
// The strobed register port and the register addresses were chosen for this implementation.
module tpg_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input tpg_pkg::tpg_bus_req_type reg_req,
  output logic [31:0] reg_rdata,
  // Trigger counter inputs from the formatter.
  input wire logic [7:0] trigger_word_count,
  input wire logic trigger_event,
  input wire logic word_strobe,
  // Pattern repeat count from its own register.
  input wire logic [7:0] pattern_repeat_count,
  // Trace port outputs.
  output logic trigger_insert,
  output logic pattern_active,
  output logic [31:0] trace_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Next enabled pattern above cur, wrapping around to the lowest.
  function automatic logic [1:0] next_pattern(input logic [3:0] en, input logic [1:0] cur);
    logic [1:0] idx;
    logic [1:0] found;
    logic hit;
    found = cur;
    hit = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      idx = 2'(cur + 2'(i));
      if (!hit && en[idx]) begin
        found = idx;
        hit = 1'b1;
      end
    end
    return found;
  endfunction : next_pattern

  // Lowest enabled pattern, which is where every sequence starts.
  function automatic logic [1:0] first_pattern(input logic [3:0] en);
    logic [1:0] found;
    logic hit;
    found = 2'h0;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!hit && en[i]) begin
        found = 2'(i);
        hit = 1'b1;
      end
    end
    return found;
  endfunction : first_pattern

  // Pattern word for a given pattern and step within it.
  function automatic logic [31:0] pattern_word(input logic [1:0] sel, input logic [4:0] step);
    logic [31:0] word;
    word = 32'h00000000;
    unique case (sel)
      2'(tpg_pkg::WALKING_ONE_POS): word = 32'h00000001 << step; // R23
      2'(tpg_pkg::WALKING_ZERO_POS): word = ~(32'h00000001 << step); // R23
      2'(tpg_pkg::ALTERNATING_BYTE_POS): word = {4{step[0] ? tpg_pkg::BYTE_ALT_B
                                                          : tpg_pkg::BYTE_ALT_A}}; // R23
      2'(tpg_pkg::ONES_ZEROS_POS): word = {4{step[0] ? tpg_pkg::BYTE_ALL_ZEROS
                                                     : tpg_pkg::BYTE_ALL_ONES}}; // R23
    endcase
    return word;
  endfunction : pattern_word

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  tpg_pkg::tpg_state_type state_reg;
  tpg_pkg::tpg_state_type state_next;

  logic [4:0] scale_exp;
  logic [30:0] prescale_last;
  logic prescale_wrap;
  logic scale_write;
  logic mode_write;
  logic [31:0] mode_word;
  logic [31:0] status_word;
  logic run_ok;
  logic pattern_done;
  logic [1:0] pat_following;
  logic pass_end;

  // Total exponent of the enabled stages; the product of powers of two is a sum.
  always_comb begin
    scale_exp = 5'h00; // R06
    if (state_reg.scale[4]) scale_exp = 5'(scale_exp + tpg_pkg::SCALE_EXP_65536); // R01
    if (state_reg.scale[3]) scale_exp = 5'(scale_exp + tpg_pkg::SCALE_EXP_256); // R02
    if (state_reg.scale[2]) scale_exp = 5'(scale_exp + tpg_pkg::SCALE_EXP_16); // R03
    if (state_reg.scale[1]) scale_exp = 5'(scale_exp + tpg_pkg::SCALE_EXP_4); // R04
    if (state_reg.scale[0]) scale_exp = 5'(scale_exp + tpg_pkg::SCALE_EXP_2); // R05
  end

  // The prescaler wraps after 2^exp words; with no stage enabled that is every word.
  assign prescale_last = 31'((32'h00000001 << scale_exp) - 32'h00000001); // R06
  assign prescale_wrap = state_reg.prescale == prescale_last;

  // Register decode.
  assign scale_write = reg_req.write && reg_req.addr == tpg_pkg::ADDR_SCALE_SELECT;
  assign mode_write = reg_req.write && reg_req.addr == tpg_pkg::ADDR_MODE_CONTROL;

  // Read views of the mode control and status registers.
  always_comb begin
    mode_word = 32'h00000000;
    mode_word[tpg_pkg::CONTINUOUS_MODE_POS] = state_reg.cont; // R16
    mode_word[tpg_pkg::TIMED_MODE_POS] = state_reg.timed; // R17
    mode_word[3:0] = state_reg.pat_en;
    status_word = {16'h0000, state_reg.trig_cnt, 3'h0, state_reg.armed,
                   state_reg.active, 1'b0, state_reg.pat_sel};
  end

  // Sequencer decisions for the running pattern.
  assign run_ok = (state_reg.cont || state_reg.timed) && (|state_reg.pat_en);
  assign pattern_done = state_reg.rep_cnt <= 8'h01; // R22
  assign pat_following = next_pattern(state_reg.pat_en, state_reg.pat_sel); // R24
  // A pass ends when the next enabled pattern is not above the current one.
  assign pass_end = pat_following <= state_reg.pat_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Hardware updates are applied first so that a software write in the same
  // cycle overrides them; a mode write always wins over the timed auto clear.
  always_comb begin
    state_next = state_reg;
    state_next.trig_pulse = 1'b0;

    // Trigger counter: load on an event, count words through the prescaler.
    if (trigger_event && !state_reg.armed) begin
      if (trigger_word_count == 8'h00) begin
        state_next.trig_pulse = 1'b1;
      end else begin
        state_next.armed = 1'b1;
        state_next.trig_cnt = trigger_word_count;
        state_next.prescale = 31'h00000000;
      end
    end else if (state_reg.armed && word_strobe) begin
      if (prescale_wrap) begin // R06
        state_next.prescale = 31'h00000000;
        if (state_reg.trig_cnt <= 8'h01) begin
          state_next.trig_cnt = 8'h00;
          state_next.armed = 1'b0;
          state_next.trig_pulse = 1'b1;
        end else begin
          state_next.trig_cnt = 8'(state_reg.trig_cnt - 8'h01);
        end
      end else begin
        state_next.prescale = 31'(state_reg.prescale + 31'h00000001);
      end
    end

    // A scale write restarts the count from the programmed value.
    if (scale_write) begin
      state_next.scale = reg_req.wdata[tpg_pkg::SCALE_STAGES-1:0];
      state_next.trig_cnt = trigger_word_count; // R07
      state_next.prescale = 31'h00000000; // R07
    end

    // Pattern sequencer.
    if (run_ok) begin
      state_next.active = 1'b1;
      state_next.trace = pattern_word(state_reg.pat_sel, state_reg.step); // R23
      state_next.step = 5'(state_reg.step + 5'h01); // R23
      state_next.rep_cnt = 8'(state_reg.rep_cnt - 8'h01);
      if (pattern_done) begin
        state_next.pat_sel = pat_following; // R24
        state_next.step = 5'h00;
        state_next.rep_cnt = pattern_repeat_count; // R22
        if (state_reg.timed && pass_end) begin
          state_next.timed = 1'b0; // R14
        end
      end
    end else begin
      state_next.active = 1'b0;
      state_next.trace = 32'h00000000;
      state_next.step = 5'h00;
    end

    // Mode write: continuous takes precedence so both modes never coexist.
    if (mode_write) begin
      state_next.cont = reg_req.wdata[tpg_pkg::CONTINUOUS_MODE_POS]; // R16
      state_next.timed = reg_req.wdata[tpg_pkg::TIMED_MODE_POS] &&
                         !reg_req.wdata[tpg_pkg::CONTINUOUS_MODE_POS]; // R12 R17
      state_next.pat_en[tpg_pkg::ONES_ZEROS_POS] =
        reg_req.wdata[tpg_pkg::ONES_ZEROS_POS]; // R18
      state_next.pat_en[tpg_pkg::ALTERNATING_BYTE_POS] =
        reg_req.wdata[tpg_pkg::ALTERNATING_BYTE_POS]; // R19
      state_next.pat_en[tpg_pkg::WALKING_ZERO_POS] =
        reg_req.wdata[tpg_pkg::WALKING_ZERO_POS]; // R20
      state_next.pat_en[tpg_pkg::WALKING_ONE_POS] =
        reg_req.wdata[tpg_pkg::WALKING_ONE_POS]; // R21 R13
      state_next.pat_sel = first_pattern(reg_req.wdata[3:0]); // R24
      state_next.step = 5'h00;
      state_next.rep_cnt = pattern_repeat_count;
    end

    // Read data stands only in the cycle after the read strobe.
    state_next.rdata = 32'h00000000;
    if (reg_req.read) begin
      unique case (reg_req.addr)
        tpg_pkg::ADDR_SCALE_SELECT: state_next.rdata = {27'h0000000, state_reg.scale};
        tpg_pkg::ADDR_CAPABILITY: state_next.rdata = tpg_pkg::CAPABILITY_VALUE; // R08 R09 R10 R11
        tpg_pkg::ADDR_MODE_CONTROL: state_next.rdata = mode_word;
        tpg_pkg::ADDR_STATUS: state_next.rdata = status_word;
        default: state_next.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset; the mode control fields come back as off with no pattern.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.scale <= tpg_pkg::SCALE_RESET;
      {state_reg.cont, state_reg.timed} <= tpg_pkg::MODE_RESET[17:16]; // R15
      state_reg.pat_en <= tpg_pkg::MODE_RESET[3:0]; // R15
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs, all straight from flip-flops.
  assign reg_rdata = state_reg.rdata;
  assign trigger_insert = state_reg.trig_pulse;
  assign pattern_active = state_reg.active;
  assign trace_data = state_reg.trace;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // The two mode bits are never set together.
  a_mode_exclusive: assert property (@(posedge clk) disable iff (!reset_n) // R12
    !(state_reg.cont && state_reg.timed))
    else $error("Continuous and timed mode both set.");

  // A capability read returns the fixed capability word next cycle.
  a_capability_read: assert property (@(posedge clk) disable iff (!reset_n) // R09
    reg_req.read && reg_req.addr == tpg_pkg::ADDR_CAPABILITY |=> reg_rdata == 32'h0003000F)
    else $error("Capability word wrong.");

  // Reset leaves the mode control at zero.
  a_mode_reset: assert property (@(posedge clk) // R15
    !reset_n |=> !state_reg.cont && !state_reg.timed && state_reg.pat_en == 4'h0)
    else $error("Mode control not zero after reset.");

  // A scale write reloads the trigger count and clears the prescaler.
  a_scale_reload: assert property (@(posedge clk) disable iff (!reset_n) // R07
    scale_write |=> state_reg.prescale == 31'h00000000 &&
                    state_reg.trig_cnt == $past(trigger_word_count))
    else $error("Scale write did not reload the counter.");

  // With only bit zero set the prescaler wraps after two words.
  a_scale_by_two: assert property (@(posedge clk) disable iff (!reset_n) // R05
    state_reg.scale == 5'h01 |-> prescale_last == 31'h00000001)
    else $error("Scale by two wrong.");

  // All stages together give a multiplier of two to the thirty-first.
  a_scale_full: assert property (@(posedge clk) disable iff (!reset_n) // R01
    state_reg.scale == 5'h1F |-> prescale_last == 31'h7FFFFFFF)
    else $error("Full scale wrong.");

  // With no stage enabled every word decrements the armed trigger counter.
  a_scale_unity: assert property (@(posedge clk) disable iff (!reset_n) // R06
    state_reg.scale == 5'h00 && state_reg.armed && word_strobe && !scale_write &&
    state_reg.trig_cnt > 8'h01 |=> state_reg.trig_cnt == $past(state_reg.trig_cnt) - 8'h01)
    else $error("Unity scale did not count.");

  // Walking ones shows a single set bit on the port.
  a_walking_one: assert property (@(posedge clk) disable iff (!reset_n) // R21
    run_ok && state_reg.pat_sel == 2'h0 |=> $onehot(trace_data))
    else $error("Walking ones not one-hot.");

  // Timed mode drops once its last pattern ends, unless software rewrites it.
  a_timed_clear: assert property (@(posedge clk) disable iff (!reset_n) // R14
    state_reg.timed && run_ok && pattern_done && pass_end && !mode_write |=> !state_reg.timed)
    else $error("Timed mode did not clear.");

  // A pattern lasts the repeat count before the selection moves on.
  a_pattern_hold: assert property (@(posedge clk) disable iff (!reset_n) // R22
    run_ok && !pattern_done && !mode_write |=> state_reg.pat_sel == $past(state_reg.pat_sel))
    else $error("Pattern switched early.");

  // Main scenarios.
  c_trigger_fired: cover property (@(posedge clk) disable iff (!reset_n) trigger_insert);
  c_timed_run: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg.timed ##1 !state_reg.timed);
  c_all_patterns: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg.cont && state_reg.pat_en == 4'hF && pattern_done);
  c_scaled_count: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg.scale != 5'h00 && prescale_wrap && word_strobe);

endmodule : tpg_top

// ### verification/tpg_capture_model.sv
////////////////////////////////////////////////////////////////////////////////
// Far side of the trace port: a capture device that keeps every flagged word.
module tpg_capture_model (
  // Clock.
  input wire logic clk,
  // Trace port.
  input wire logic pattern_active,
  input wire logic [31:0] trace_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] words[$];
  int idle_bad;

  // Only flagged words are patterns; an idle port must read zero, or a detector would lock on noise.
  initial idle_bad = 0;
  always @(posedge clk) begin
    if (pattern_active === 1'b1) begin
      words.push_back(trace_data);
    end else if (trace_data !== 32'h0) begin
      idle_bad++;
    end
  end
endmodule : tpg_capture_model

// ### verification/testbench.sv
////////////////////////////////////////////////////////////////////////////////
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic reset_n;
  tpg_pkg::tpg_bus_req_type reg_req;
  logic [31:0] reg_rdata;
  logic [7:0] trigger_word_count;
  logic trigger_event;
  logic word_strobe;
  logic [7:0] pattern_repeat_count;
  logic trigger_insert;
  logic pattern_active;
  logic [31:0] trace_data;
  int n_errors;
  int n_tests;

  tpg_top i_dut (
    .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .trigger_word_count(trigger_word_count), .trigger_event(trigger_event),
    .word_strobe(word_strobe), .pattern_repeat_count(pattern_repeat_count),
    .trigger_insert(trigger_insert), .pattern_active(pattern_active), .trace_data(trace_data)
  );

  tpg_capture_model i_cap (.clk(clk), .pattern_active(pattern_active), .trace_data(trace_data));

  // Free running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Report and compare.
  task give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task check32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check32

  // Expected pattern word; the step restarts at zero for every pattern.
  function automatic logic [31:0] pat_word(int idx, int step);
    case (idx)
      0: return 32'h1 << (step % 32);
      1: return ~(32'h1 << (step % 32));
      2: return (step % 2 == 0) ? 32'hAAAAAAAA : 32'h55555555;
      default: return (step % 2 == 0) ? 32'hFFFFFFFF : 32'h00000000;
    endcase
  endfunction : pat_word

  function automatic int scale_exp(logic [4:0] s);
    return 16 * s[4] + 8 * s[3] + 4 * s[2] + 2 * s[1] + s[0];
  endfunction : scale_exp

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks; each leaves an idle cycle so no strobe is assigned twice in one step.
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    reg_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1;
    check32(reg_rdata, exp);
    @(posedge clk);
  endtask : rd

  // Runs one pattern job and compares the captured words of one pass (two in continuous mode) against the expected order.
  task run_pat(input logic cont, input logic [3:0] mask, input logic [7:0] rc);
    int per, pass, want, k, i, r, idx, s;
    per = (rc == 8'h00) ? 1 : rc;
    pass = per * $countones(mask);
    want = cont ? 2 * pass : pass;
    pattern_repeat_count <= rc;
    i_cap.words.delete();
    wr(tpg_pkg::ADDR_MODE_CONTROL, {14'h0, cont, ~cont, 12'h0, mask});
    for (k = 0; k < 3000 && i_cap.words.size() < want; k++) @(posedge clk);
    if (k == 3000) begin
      n_errors++;
      give_verdict();
    end
    if (cont) wr(tpg_pkg::ADDR_MODE_CONTROL, 32'h0);
    else repeat (4) @(posedge clk);
    if (!cont) check32(i_cap.words.size(), pass);
    i = 0;
    for (r = 0; r < (cont ? 2 : 1); r++)
      for (idx = 0; idx < 4; idx++)
        if (mask[idx])
          for (s = 0; s < per; s++) begin
            check32(i_cap.words[i], pat_word(idx, s));
            i++;
          end
    rd(tpg_pkg::ADDR_MODE_CONTROL, {28'h0, cont ? 4'h0 : mask});
    $display("pattern test cont=%0d mask=%h count=%0d done", cont, mask, rc);
  endtask : run_pat

  // Counts word strobes until the trigger is inserted; pre strobes are discarded by a rewrite.
  task run_trig(input logic [4:0] sel, input logic [7:0] cnt, input int pre);
    int n, k;
    trigger_word_count <= cnt;
    wr(tpg_pkg::ADDR_SCALE_SELECT, {27'h0, sel});
    rd(tpg_pkg::ADDR_SCALE_SELECT, {27'h0, sel});
    trigger_event <= 1'b1;
    @(posedge clk);
    trigger_event <= 1'b0;
    if (cnt == 8'h00) begin
      // A zero count inserts the trigger at once, with no word strobes.
      #1;
      check32({31'h0, trigger_insert}, 32'h1);
      @(posedge clk);
    end else begin
      if (pre > 0) begin
        word_strobe <= 1'b1;
        repeat (pre) @(posedge clk);
        word_strobe <= 1'b0;
        wr(tpg_pkg::ADDR_SCALE_SELECT, {27'h0, sel});
      end
      word_strobe <= 1'b1;
      n = 0;
      for (k = 0; k < 70000; k++) begin
        @(posedge clk);
        n++;
        #1;
        if (trigger_insert === 1'b1) break;
      end
      if (k == 70000) begin
        n_errors++;
        give_verdict();
      end
      // The strobe drops on an edge; the extra strobe is ignored once the counter is idle.
      @(posedge clk);
      word_strobe <= 1'b0;
      check32(n, 32'(cnt) << scale_exp(sel));
    end
    $display("trigger test scale=%h count=%0d done", sel, cnt);
  endtask : run_trig

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    trigger_word_count = 8'h00;
    trigger_event = 1'b0;
    word_strobe = 1'b0;
    pattern_repeat_count = 8'h00;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(32'hF46E1453));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(tpg_pkg::ADDR_SCALE_SELECT, 32'h0);
    rd(tpg_pkg::ADDR_CAPABILITY, 32'h0003000F);
    rd(tpg_pkg::ADDR_MODE_CONTROL, 32'h0);
    wr(tpg_pkg::ADDR_CAPABILITY, 32'h0);
    rd(tpg_pkg::ADDR_CAPABILITY, 32'h0003000F);
    rd(8'h10, 32'h0);
    rd(tpg_pkg::ADDR_STATUS, 32'h0);
    wr(tpg_pkg::ADDR_SCALE_SELECT, 32'hFFFFFFFF);
    rd(tpg_pkg::ADDR_SCALE_SELECT, 32'h0000001F);
    $display("register test done");
    // Both mode bits at once is refused down to continuous only.
    wr(tpg_pkg::ADDR_MODE_CONTROL, 32'h00030005);
    rd(tpg_pkg::ADDR_MODE_CONTROL, 32'h00020005);
    wr(tpg_pkg::ADDR_MODE_CONTROL, 32'h0);
    $display("mode clash test done");
    // A reset in mid-run must stop the generator and clear mode and scale.
    wr(tpg_pkg::ADDR_MODE_CONTROL, 32'h0002000F);
    repeat (3) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(tpg_pkg::ADDR_MODE_CONTROL, 32'h0);
    rd(tpg_pkg::ADDR_SCALE_SELECT, 32'h0);
    check32({31'h0, pattern_active}, 32'h0);
    $display("mid-run reset test done");
    for (int p = 0; p < 4; p++) run_pat(1'b0, 4'h1 << p, 8'h03);
    run_pat(1'b0, 4'hF, 8'h00);
    for (int t = 0; t < 6; t++)
      run_pat(t[0], 4'($urandom_range(15, 1)), 8'($urandom_range(6, 1)));
    run_trig(5'h00, 8'h00, 0);
    run_trig(5'h00, 8'h02, 0);
    run_trig(5'h01, 8'h03, 4);
    for (int t = 0; t < 4; t++)
      run_trig(5'($urandom_range(7, 1)), 8'($urandom_range(3, 1)), 0);
    run_trig(5'h08, 8'h02, 0);
    run_trig(5'h10, 8'h01, 0);
    check32(i_cap.idle_bad, 32'h0);
    give_verdict();
  end
endmodule : testbench
